// file: verification/fms_meter_model.sv
// Multimeter model answering the handshake start line with done.
`timescale 1ns/1ps
module fms_meter_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] delay,
  input  wire logic       measStart,
  output logic            measDone
);
  logic [4:0] cntQ;
  logic [4:0] cntD;
  logic       doneD;
  // Done follows start after delay plus two cycles, so slow meters stall.
  always_comb
  begin
    cntD  = cntQ;
    doneD = 1'b0;
    if (measStart)
    begin
      cntD = {1'b0, delay} + 5'h01;
    end
    else if (cntQ != 5'h00)
    begin
      cntD  = cntQ - 5'h01;
      doneD = (cntQ == 5'h01);
    end
  end
  always_ff @(posedge clk)
  begin
    cntQ     <= rst ? 5'h00 : cntD;
    measDone <= rst ? 1'b0 : doneD;
  end
endmodule : fms_meter_model

// file: verification/fms_seq_assertions.sv
// Port checker of the FET channel switch sequencer.
`timescale 1ns/1ps
module fms_seq_assertions #(
  parameter int NCARDS = 2
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire fms_pkg::fms_req_s    req,
  input wire fms_pkg::fms_route_e  routeSel,
  input wire logic                 routeWrite,
  input wire fms_pkg::fms_mode_e   modeSel,
  input wire logic                 modeWrite,
  input wire fms_pkg::fms_src_e    srcSel,
  input wire logic                 syncOutEn,
  input wire logic                 eventIn,
  input wire logic                 respRead,
  input wire logic [NCARDS*16-1:0] closedMap,
  input wire logic [NCARDS-1:0]    bank0Direct,
  input wire logic [NCARDS-1:0]    bank1Direct,
  input wire fms_pkg::fms_route_s  routeOut,
  input wire logic                 respValid,
  input wire logic                 respBit,
  input wire logic                 respError,
  input wire logic                 trigOut,
  input wire logic                 running
);
  import fms_pkg::*;
  logic fourQ;
  logic fourD;
  logic qBit;
  int   qIdx;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign qIdx = (int'(req.addr.card) - 1) * 16 + int'(req.addr.chan);
  always_comb
  begin
    qBit  = closedMap[qIdx];
    fourD = modeWrite ? (modeSel == FMS_MODE_FOUR_WIRE) : fourQ;
  end
  always_ff @(posedge clk)
  begin
    fourQ <= rst ? 1'b0 : fourD;
  end
  property p_one;
    !fourQ |-> $countones(closedMap[15:0]) <= 1
      && $countones(closedMap[31:16]) <= 1;
  endproperty
  a_one: assert property (p_one) else $error("two closed on a card");
  property p_bank;
    bank0Direct[0] == |closedMap[7:0] && bank1Direct[0] == |closedMap[15:8];
  endproperty
  a_bank: assert property (p_bank) else $error("bank terminal wrong");
  property p_none;
    routeWrite && routeSel == FMS_ROUTE_NONE
      |=> ##1 !routeOut.treeAClosed && !routeOut.treeBClosed;
  endproperty
  a_none: assert property (p_none) else $error("tree not opened");
  property p_analog_bus_routing;
    routeWrite && routeSel == FMS_ROUTE_ANALOG_BUS
      |=> ##1 routeOut.treeAClosed && routeOut.treeBClosed;
  endproperty
  a_analog_bus_routing: assert property (p_analog_bus_routing) else $error("tree not closed");
  property p_break;
    $past(closedMap[15:0]) != 0 && closedMap[15:0] != 0
      |-> $stable(closedMap[15:0]);
  endproperty
  a_break: assert property (p_break) else $error("make before break");
  property p_pair;
    fourQ |-> closedMap[15:8] == closedMap[7:0];
  endproperty
  a_pair: assert property (p_pair) else $error("pair not matched");
  property p_query;
    req.valid && req.cmd inside {FMS_CMD_QRY_CLOSED, FMS_CMD_QRY_OPEN}
      && req.addr.card inside {[1:NCARDS]} && !respValid
      |=> respValid && respBit == ($past(qBit)
      ^ ($past(req.cmd) == FMS_CMD_QRY_OPEN));
  endproperty
  a_query: assert property (p_query) else $error("query answer wrong");
  property p_unread;
    req.valid && req.cmd != FMS_CMD_NOP && respValid && !respRead
      |=> respError;
  endproperty
  a_unread: assert property (p_unread) else $error("no unread error");
  property p_trig;
    trigOut |-> $past(syncOutEn) && !$past(srcSel[1]);
  endproperty
  a_trig: assert property (p_trig) else $error("stray sync pulse");
  sequence s_quiet;
    !req.valid [*6];
  endsequence
  property p_idle;
    s_quiet ##0 (!running && eventIn) |=> $stable(closedMap) [*3];
  endproperty
  a_idle: assert property (p_idle) else $error("idle advance");
  c_pair: cover property (fourQ && closedMap[2] && closedMap[10]);
  c_trig: cover property (trigOut);
  c_err: cover property (respError);
  c_step: cover property (running && $changed(closedMap));
endmodule : fms_seq_assertions
bind fms_sequencer fms_seq_assertions #(.NCARDS(NCARDS)) chk_u (
  .clk(clk), .rst(rst), .req(req), .routeSel(routeSel),
  .routeWrite(routeWrite), .modeSel(modeSel), .modeWrite(modeWrite),
  .srcSel(srcSel), .syncOutEn(syncOutEn), .eventIn(eventIn),
  .respRead(respRead), .closedMap(closedMap), .bank0Direct(bank0Direct),
  .bank1Direct(bank1Direct), .routeOut(routeOut), .respValid(respValid),
  .respBit(respBit), .respError(respError), .trigOut(trigOut),
  .running(running));

// file: verification/tb_top.sv
// Self-checking bench of the FET channel switch sequencer.
`timescale 1ns/1ps
module tb_top;
  import fms_pkg::*;
  logic clk, rst, listClear, listAppend, routeWrite, modeWrite;
  logic syncOutEn, eventIn, measDone, respRead, measStart;
  logic respValid, respBit, respError, trigOut, running;
  fms_req_s    req;
  fms_addr_s   listAddr;
  fms_route_e  routeSel;
  fms_mode_e   modeSel;
  fms_src_e    srcSel;
  fms_route_s  routeOut;
  logic [31:0] closedMap;
  logic [1:0]  bank0Direct, bank1Direct;
  logic [3:0]  meterDelay;
  int          errorCnt, numChecks, trigCnt, t0;
  fms_sequencer dut_u (.clk(clk), .rst(rst), .req(req),
    .listClear(listClear), .listAppend(listAppend), .listAddr(listAddr),
    .routeSel(routeSel), .routeWrite(routeWrite), .modeSel(modeSel),
    .modeWrite(modeWrite), .srcSel(srcSel), .syncOutEn(syncOutEn),
    .eventIn(eventIn), .measDone(measDone), .respRead(respRead),
    .closedMap(closedMap), .bank0Direct(bank0Direct),
    .bank1Direct(bank1Direct), .routeOut(routeOut), .respValid(respValid),
    .respBit(respBit), .respError(respError), .trigOut(trigOut),
    .measStart(measStart), .running(running));
  fms_meter_model meter_u (.clk(clk), .rst(rst), .delay(meterDelay),
    .measStart(measStart), .measDone(measDone));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (trigOut === 1'b1)
      trigCnt++;
  // ****************************************
  // Drivers and compares
  // ****************************************
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    numChecks++;
    if (g !== e)
    begin
      errorCnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic waitMap(logic [31:0] e);
    for (int k = 0; k < 20 && closedMap !== e; k++)
      @(posedge clk) #1;
    chk("closedMap", e, closedMap);
  endtask : waitMap
  task automatic doReset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : doReset
  task automatic cmd(fms_cmd_e c, logic [7:0] cd, logic [3:0] ch);
    @(posedge clk);
    req <= '{1'b1, c, '{cd, ch}};
    @(posedge clk);
    req <= '0;
  endtask : cmd
  task automatic qry(fms_cmd_e c, logic [3:0] ch, logic e);
    cmd(c, 8'h01, ch);
    @(posedge clk) #1;
    chk("respBit", {31'h0, e}, {31'h0, respBit});
    @(posedge clk);
    respRead <= 1'b1;
    @(posedge clk);
    respRead <= 1'b0;
  endtask : qry
  task automatic setCfg(fms_route_e r, fms_mode_e m);
    @(posedge clk);
    {routeSel, modeSel, routeWrite, modeWrite} <= {r, m, 2'h3};
    @(posedge clk);
    {routeWrite, modeWrite} <= 2'h0;
    @(posedge clk) #1;
  endtask : setCfg
  task automatic evt();
    @(posedge clk);
    eventIn <= 1'b1;
    @(posedge clk);
    eventIn <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : evt
  task automatic load(logic [7:0] cd, logic [3:0] ch, fms_src_e s);
    @(posedge clk);
    {listAppend, listAddr, srcSel, syncOutEn} <= {1'b1, cd, ch, s, 1'b1};
    @(posedge clk);
    listAppend <= 1'b0;
  endtask : load
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tDirect();
    chk("routeOut", 32'h0, {27'h0, routeOut});
    cmd(FMS_CMD_CLOSE, 8'h01, 4'h2);
    waitMap(32'h0000_0004);
    chk("bank0Direct", 32'h1, {30'h0, bank0Direct});
    cmd(FMS_CMD_CLOSE, 8'h01, 4'h9);
    waitMap(32'h0000_0200);
    cmd(FMS_CMD_CLOSE, 8'h02, 4'h8);
    waitMap(32'h0100_0200);
    qry(FMS_CMD_QRY_OPEN, 4'h9, 1'b0);
    for (int k = 0; k < 16; k++)
      qry(FMS_CMD_QRY_CLOSED, 4'(k), k == 9);
  endtask : tDirect
  task automatic tRoute();
    setCfg(FMS_ROUTE_ANALOG_BUS, FMS_MODE_RES);
    chk("treeAB", 32'h3, {30'h0, routeOut[4:3]});
    setCfg(FMS_ROUTE_NONE, FMS_MODE_VOLT);
    chk("treeAB", 32'h0, {30'h0, routeOut[4:3]});
    cmd(FMS_CMD_QRY_CLOSED, 8'h01, 4'h0);
    cmd(FMS_CMD_QRY_CLOSED, 8'h01, 4'h1);
    @(posedge clk) #1;
    chk("respError", 32'h1, {31'h0, respError});
    doReset();
  endtask : tRoute
  task automatic tFour();
    setCfg(FMS_ROUTE_ANALOG_BUS, FMS_MODE_FOUR_WIRE);
    cmd(FMS_CMD_CLOSE, 8'h01, 4'h2);
    waitMap(32'h0000_0404);
    chk("bankSplit", 32'h1, {31'h0, routeOut.bankSplit});
    cmd(FMS_CMD_CLOSE, 8'h01, 4'hF);
    waitMap(32'h0000_8080);
    doReset();
  endtask : tFour
  task automatic tScan();
    load(8'h01, 4'hE, FMS_SRC_BUS);
    load(8'h01, 4'hF, FMS_SRC_BUS);
    load(8'h02, 4'h0, FMS_SRC_BUS);
    evt();
    waitMap(32'h0);
    t0 = trigCnt;
    cmd(FMS_CMD_START, 8'h00, 4'h0);
    waitMap(32'h0000_4000);
    evt();
    waitMap(32'h0000_4000);
    cmd(FMS_CMD_TRIGGER, 8'h00, 4'h0);
    waitMap(32'h0000_8000);
    cmd(FMS_CMD_TRIGGER, 8'h00, 4'h0);
    waitMap(32'h0001_0000);
    cmd(FMS_CMD_TRIGGER, 8'h00, 4'h0);
    waitMap(32'h0000_4000);
    @(posedge clk);
    srcSel <= FMS_SRC_EXT;
    evt();
    waitMap(32'h0000_8000);
    chk("trigOut", 32'h5, 32'(trigCnt - t0));
    cmd(FMS_CMD_STOP, 8'h00, 4'h0);
    doReset();
  endtask : tScan
  task automatic tHandshake();
    load(8'h01, 4'h3, FMS_SRC_DIGITAL_BUS);
    load(8'h01, 4'h4, FMS_SRC_DIGITAL_BUS);
    t0 = trigCnt;
    cmd(FMS_CMD_START, 8'h00, 4'h0);
    waitMap(32'h0000_0008);
    waitMap(32'h0000_0010);
    @(posedge clk);
    meterDelay <= 4'h9;
    waitMap(32'h0000_0008);
    chk("trigOut", 32'h0, 32'(trigCnt - t0));
    cmd(FMS_CMD_STOP, 8'h00, 4'h0);
    @(posedge clk);
    srcSel <= FMS_SRC_FREE_RUNNING;
    cmd(FMS_CMD_START, 8'h00, 4'h0);
    waitMap(32'h0000_0010);
    waitMap(32'h0000_0008);
    chk("trigOut", 32'h0, 32'(trigCnt - t0));
  endtask : tHandshake
  task automatic finishTest();
    if (errorCnt == 0 && numChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finishTest
  initial
  begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    finishTest();
  end
  initial
  begin
    rst = 1'b1;
    req = '0;
    listAddr = '0;
    {listClear, listAppend, routeWrite, modeWrite} = 4'h0;
    {syncOutEn, eventIn, respRead} = 3'h0;
    routeSel = FMS_ROUTE_NONE;
    modeSel = FMS_MODE_VOLT;
    srcSel = FMS_SRC_BUS;
    meterDelay = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) #1;
    tDirect();
    tRoute();
    tFour();
    tScan();
    tHandshake();
    finishTest();
  end
endmodule : tb_top

// file: verilog/fms_card_switch.sv
// One card's break-before-make channel switch with independent state.
`timescale 1ns/1ps
`include "fms_cfg.svh"
module fms_card_switch #(
  parameter int BREAK_CYC = `FMS_BREAK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic        openAll,
  input  wire logic        pairEn,
  input  wire logic [3:0]  chan,
  output logic      [15:0] closed,
  output logic             busy
);
  import fms_pkg::*;
  localparam int CW = $clog2(BREAK_CYC + 1);
  logic [15:0] closed_q, closed_d, target_q, target_d;
  logic [CW-1:0] wait_q, wait_d;
  logic          pend_q, pend_d;
  logic [15:0]   want;

  // ******************************
  // Break-before-make sequencing
  // ******************************
  always_comb
  begin
    want = 16'h0000;
    want[chan] = 1'b1;
    if (pairEn)
      want[chan ^ 4'h8] = 1'b1;             // [RULE16]
    closed_d = closed_q;
    target_d = target_q;
    wait_d   = wait_q;
    pend_d   = pend_q;
    if (load || openAll)
    begin
      closed_d = 16'h0000;                  // [RULE8] [RULE23]
      target_d = load ? want : 16'h0000;    // [RULE6]
      pend_d   = load;
      wait_d   = CW'(BREAK_CYC);
    end
    else if (pend_q)
    begin
      if (wait_q > CW'(1))
        wait_d = wait_q - CW'(1);
      else
      begin
        closed_d = target_q;                // [RULE8]
        pend_d   = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      closed_q <= 16'h0000;
      target_q <= 16'h0000;
      wait_q   <= '0;
      pend_q   <= 1'b0;
    end
    else
    begin
      closed_q <= closed_d;
      target_q <= target_d;
      wait_q   <= wait_d;
      pend_q   <= pend_d;
    end
  end

  assign closed = closed_q;
  assign busy   = pend_q;
endmodule : fms_card_switch

// file: verilog/fms_cfg.svh
// Constants for the FET channel switch sequencer.
`ifndef FMS_CFG_SVH
`define FMS_CFG_SVH
// Overview of operation
// (RULE1) Channels 0 to 7 connect to the bank-zero direct terminal when closed.
// (RULE2) Channels 8 to 15 connect to the bank-one direct terminal when closed.
// (RULE3) Routing none opens both A and B tree isolation switches.
// (RULE4) Reset sets routing to none with both tree switches open.
// (RULE5) Analog bus routing shows the closed channel at direct, A tree, bus.
// (RULE6) One channel closed per card, except a pair in four-wire mode.
// (RULE7) Each card keeps its own closure state independently.
// (RULE8) Open the old switch fully before closing the next one.
// (RULE9) A running sequence advances only on the selected source's event.
// (RULE10) Closure query gives 1 for closed; openness query gives inverse.
// (RULE11) Range query returns one value per channel in list order. Here a query names one channel and returns one value; there is no range query.
// (RULE12) An unread query answer left pending raises an error.
// (RULE13) Analog bus routing closes both A and B tree isolation sets.
// (RULE14) A tree carries sense lines and guard; B tree source lines, guard.
// (RULE15) Four-wire mode separates banks; B stimulus, A response.
// (RULE16) Four-wire closes partner eight away; named to A, partner to B. Here bank zero alone goes to A, so a named channel 8 to 15 is off A.
// (RULE17) Bus source advances on each host trigger command. Triggers are dropped while a card is busy or the next channel loads.
// (RULE18) External source needs outside pulses on the event input.
// (RULE19) Sync output pulses trigger out except handshake and free running.
// (RULE20) Handshake mode exchanges done and start lines, fastest rate.
// (RULE21) Start closes first list channel; each advance moves to next. Start here closes the entry at the pointer, the first only if it is 0.
// (RULE22) Ranges walk card then channel order across cards. Here there are no ranges; a sequence walks the list in append order.
// (RULE23) Closing a channel opens all others on that card first.
// (RULE24) Channel address is card number then channel number.
// (RULE25) After the last channel the pointer wraps to the first.
// (RULE26) Advance events are ignored while no sequence is started.
`define FMS_ROUTE_RESET   2'h0
`define FMS_MODE_RESET    2'h0
`define FMS_BREAK_NS      20
`define FMS_CLK_NS        10
`define FMS_BREAK_CYC     ((`FMS_BREAK_NS + `FMS_CLK_NS - 1) / `FMS_CLK_NS)
`define FMS_PAIR_OFFSET   5'h08
`define FMS_BANK_BIT      3
`define FMS_TRIG_PULSE_CYC 1
`endif

// file: verilog/fms_pkg.sv
// Types for the FET channel switch sequencer.
package fms_pkg;
  typedef enum logic [1:0] {
    FMS_ROUTE_NONE = 2'h0,
    FMS_ROUTE_ANALOG_BUS = 2'h1
  } fms_route_e;
  typedef enum logic [1:0] {
    FMS_MODE_VOLT = 2'h0,
    FMS_MODE_RES = 2'h1,
    FMS_MODE_FOUR_WIRE = 2'h2
  } fms_mode_e;
  typedef enum logic [1:0] {
    FMS_SRC_BUS = 2'h0,
    FMS_SRC_EXT = 2'h1,
    FMS_SRC_DIGITAL_BUS = 2'h2,
    FMS_SRC_FREE_RUNNING = 2'h3
  } fms_src_e;
  typedef enum logic [2:0] {
    FMS_CMD_NOP = 3'h0,
    FMS_CMD_CLOSE = 3'h1,
    FMS_CMD_OPEN = 3'h2,
    FMS_CMD_QRY_CLOSED = 3'h3,
    FMS_CMD_QRY_OPEN = 3'h4,
    FMS_CMD_START = 3'h5,
    FMS_CMD_TRIGGER = 3'h6,
    FMS_CMD_STOP = 3'h7
  } fms_cmd_e;
  typedef struct packed {
    logic [7:0] card;
    logic [3:0] chan;
  } fms_addr_s;
  typedef struct packed {
    logic      valid;
    fms_cmd_e  cmd;
    fms_addr_s addr;
  } fms_req_s;
  typedef struct packed {
    logic treeAClosed;
    logic treeBClosed;
    logic bankSplit;
    logic bank0ToTreeA;
    logic bank1ToTreeA;
  } fms_route_s;
endpackage : fms_pkg

// file: verilog/fms_seq_list.sv
// Sequence list memory with wrap-around pointer.
`timescale 1ns/1ps
`include "fms_cfg.svh"
module fms_seq_list #(
  parameter int DEPTH = 64
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      clear,
  input  wire logic                      append,
  input  wire fms_pkg::fms_addr_s        appendAddr,
  input  wire logic                      rewind,
  input  wire logic                      step,
  output fms_pkg::fms_addr_s             curAddr,
  output logic                           nonEmpty
);
  import fms_pkg::*;
  localparam int PW = $clog2(DEPTH + 1);
  fms_addr_s   mem [DEPTH];
  logic [PW-1:0] len_q, len_d, ptr_q, ptr_d;

  always_comb
  begin
    len_d = len_q;
    ptr_d = ptr_q;
    if (clear)
    begin
      len_d = '0;
      ptr_d = '0;
    end
    else
    begin
      if (append && len_q < PW'(DEPTH))
        len_d = len_q + PW'(1);
      if (rewind)
        ptr_d = '0;
      else if (step)
        ptr_d = (ptr_q + PW'(1) >= len_q) ? '0 : ptr_q + PW'(1); // [RULE25]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      len_q <= '0;
      ptr_q <= '0;
    end
    else
    begin
      len_q <= len_d;
      ptr_q <= ptr_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!clear && append && len_q < PW'(DEPTH))
      mem[len_q[PW-2:0]] <= appendAddr;
  end

  assign curAddr  = mem[ptr_q[PW-2:0]];
  assign nonEmpty = (len_q != '0);
endmodule : fms_seq_list

// file: verilog/fms_sequencer.sv
// Top control of the FET multiplexer: routing, closures, queries, sequencing.
`timescale 1ns/1ps
`include "fms_cfg.svh"
module fms_sequencer #(
  parameter int NCARDS    = 2,
  parameter int BREAK_CYC = `FMS_BREAK_CYC,
  parameter int DEPTH     = 64
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire fms_pkg::fms_req_s         req,
  input  wire logic                      listClear,
  input  wire logic                      listAppend,
  input  wire fms_pkg::fms_addr_s        listAddr,
  input  wire fms_pkg::fms_route_e       routeSel,
  input  wire logic                      routeWrite,
  input  wire fms_pkg::fms_mode_e        modeSel,
  input  wire logic                      modeWrite,
  input  wire fms_pkg::fms_src_e         srcSel,
  input  wire logic                      syncOutEn,
  input  wire logic                      eventIn,
  input  wire logic                      measDone,
  input  wire logic                      respRead,
  output logic [NCARDS*16-1:0]           closedMap,
  output logic [NCARDS-1:0]              bank0Direct,
  output logic [NCARDS-1:0]              bank1Direct,
  output fms_pkg::fms_route_s            routeOut,
  output logic                           respValid,
  output logic                           respBit,
  output logic                           respError,
  output logic                           trigOut,
  output logic                           measStart,
  output logic                           running
);
  import fms_pkg::*;

  fms_route_e route_q, route_d;
  fms_mode_e  mode_q, mode_d;
  logic       run_q, run_d;
  logic       respV_q, respV_d, respB_q, respB_d, err_q, err_d;
  logic       trig_q, trig_d, mstart_q, mstart_d;
  logic [NCARDS*16-1:0] map_q;
  logic [NCARDS-1:0]    b0_q, b1_q;
  fms_route_s  rt_q, rt_d;
  logic [NCARDS-1:0]    load, openAll, busy;
  logic [15:0]          cardClosed [NCARDS];
  logic [3:0]           loadChan;
  logic                 advance, stepList, rewind;
  fms_addr_s            curAddr, tgt;
  logic                 nonEmpty, closeHit;
  logic                 stepped_q;

  function automatic logic cardHit(input fms_addr_s a, input int idx);
    cardHit = (a.card == 8'(idx + 1));      // [RULE24]
  endfunction : cardHit

  // ******************************
  // Advance event selection
  // ******************************
  always_comb
  begin
    unique case (srcSel)                    // [RULE9]
      FMS_SRC_BUS:
        advance = req.valid && req.cmd == FMS_CMD_TRIGGER; // [RULE17]
      FMS_SRC_EXT:
        advance = eventIn;                  // [RULE18]
      FMS_SRC_DIGITAL_BUS:
        advance = measDone;                 // [RULE20]
      FMS_SRC_FREE_RUNNING:
        advance = (busy == '0);
    endcase
  end

  // ******************************
  // Command decode and sequencing
  // ******************************
  always_comb
  begin
    route_d  = route_q;
    mode_d   = mode_q;
    run_d    = run_q;
    respV_d  = respV_q && !respRead;
    respB_d  = respB_q;
    err_d    = err_q;
    trig_d   = 1'b0;
    mstart_d = 1'b0;
    stepList = 1'b0;
    rewind   = 1'b0;
    load     = '0;
    openAll  = '0;
    tgt      = req.addr;
    loadChan = req.addr.chan;
    closeHit = 1'b0;
    if (routeWrite)
      route_d = routeSel;
    if (modeWrite)
      mode_d = modeSel;
    if (req.valid && respV_q && !respRead)
      err_d = 1'b1;                         // [RULE12]
    if (req.valid)
    begin
      unique case (req.cmd)
        FMS_CMD_CLOSE:
          for (int i = 0; i < NCARDS; i++)
            load[i] = cardHit(req.addr, i); // [RULE7] [RULE23]
        FMS_CMD_OPEN:
          for (int i = 0; i < NCARDS; i++)
            if (cardHit(req.addr, i) && cardClosed[i][req.addr.chan])
              openAll[i] = 1'b1;
        FMS_CMD_QRY_CLOSED, FMS_CMD_QRY_OPEN:
        begin
          closeHit = 1'b0;
          for (int i = 0; i < NCARDS; i++)
            if (cardHit(req.addr, i))
              closeHit = cardClosed[i][req.addr.chan];
          respV_d = 1'b1;                   // [RULE11]
          respB_d = (req.cmd == FMS_CMD_QRY_CLOSED) ? closeHit
                                                   : !closeHit; // [RULE10]
        end
        FMS_CMD_START:
          if (nonEmpty)
          begin
            run_d  = 1'b1;
            rewind = 1'b1;
            tgt    = curAddr;               // [RULE21]
          end
        FMS_CMD_STOP:
          run_d = 1'b0;
        default:
          ;
      endcase
    end
    if (req.valid && req.cmd == FMS_CMD_START && nonEmpty)
    begin
      loadChan = curAddr.chan;
      for (int i = 0; i < NCARDS; i++)
        load[i] = cardHit(curAddr, i);
      trig_d   = syncOutEn && srcSel != FMS_SRC_DIGITAL_BUS
                 && srcSel != FMS_SRC_FREE_RUNNING; // [RULE19]
      mstart_d = (srcSel == FMS_SRC_DIGITAL_BUS);
    end
    // A step is blocked while the next channel is still being loaded.
    else if (run_q && advance && busy == '0 && !stepped_q) // [RULE26]
    begin
      stepList = 1'b1;                      // [RULE22]
      loadChan = curAddr.chan;
    end
  end

  // Pointer moves first; the next channel is loaded one cycle later.
  always_ff @(posedge clk)
  begin
    if (rst)
      stepped_q <= 1'b0;
    else
      stepped_q <= stepList;
  end

  logic [NCARDS-1:0] loadAll;
  logic [NCARDS-1:0] openOld;
  always_comb
  begin
    for (int i = 0; i < NCARDS; i++)
    begin
      loadAll[i] = load[i] || (stepped_q && cardHit(curAddr, i));
      openOld[i] = openAll[i] || (stepList && cardClosed[i] != 16'h0000); // [RULE8]
    end
  end

  // ******************************
  // Per-card switch arrays
  // ******************************
  for (genvar g = 0; g < NCARDS; g++)
  begin : gCard
    fms_card_switch #(.BREAK_CYC(BREAK_CYC)) uSw (
      .clk     (clk),
      .rst     (rst),
      .load    (loadAll[g]),
      .openAll (openOld[g] && !loadAll[g]),
      .pairEn  (mode_q == FMS_MODE_FOUR_WIRE), // [RULE6] [RULE16]
      .chan    (stepped_q ? curAddr.chan : loadChan),
      .closed  (cardClosed[g]),
      .busy    (busy[g])
    );
  end

  fms_seq_list #(.DEPTH(DEPTH)) uList (
    .clk        (clk),
    .rst        (rst),
    .clear      (listClear),
    .append     (listAppend),
    .appendAddr (listAddr),
    .rewind     (rewind),
    .step       (stepList),
    .curAddr    (curAddr),
    .nonEmpty   (nonEmpty)
  );

  // ******************************
  // Tree isolation routing
  // ******************************
  always_comb
  begin
    rt_d = '0;                              // [RULE3]
    if (route_q == FMS_ROUTE_ANALOG_BUS)
    begin
      rt_d.treeAClosed = 1'b1;              // [RULE5] [RULE13]
      rt_d.treeBClosed = 1'b1;              // [RULE14]
      rt_d.bank0ToTreeA = 1'b1;
      rt_d.bank1ToTreeA = (mode_q != FMS_MODE_FOUR_WIRE);
      rt_d.bankSplit = (mode_q == FMS_MODE_FOUR_WIRE); // [RULE15]
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      route_q  <= fms_route_e'(`FMS_ROUTE_RESET); // [RULE4]
      mode_q   <= fms_mode_e'(`FMS_MODE_RESET);
      run_q    <= 1'b0;
      respV_q  <= 1'b0;
      respB_q  <= 1'b0;
      err_q    <= 1'b0;
      trig_q   <= 1'b0;
      mstart_q <= 1'b0;
      rt_q     <= '0;
      map_q    <= '0;
      b0_q     <= '0;
      b1_q     <= '0;
    end
    else
    begin
      route_q  <= route_d;
      mode_q   <= mode_d;
      run_q    <= run_d;
      respV_q  <= respV_d;
      respB_q  <= respB_d;
      err_q    <= err_d;
      trig_q   <= trig_d || (stepped_q && syncOutEn
                  && srcSel != FMS_SRC_DIGITAL_BUS
                  && srcSel != FMS_SRC_FREE_RUNNING);
      mstart_q <= mstart_d || (stepped_q && srcSel == FMS_SRC_DIGITAL_BUS);
      rt_q     <= rt_d;
      for (int i = 0; i < NCARDS; i++)
      begin
        map_q[i*16 +: 16] <= cardClosed[i];
        b0_q[i] <= |cardClosed[i][7:0];     // [RULE1]
        b1_q[i] <= |cardClosed[i][15:8];    // [RULE2]
      end
    end
  end

  assign closedMap   = map_q;
  assign bank0Direct = b0_q;
  assign bank1Direct = b1_q;
  assign routeOut    = rt_q;
  assign respValid   = respV_q;
  assign respBit     = respB_q;
  assign respError   = err_q;
  assign trigOut     = trig_q;
  assign measStart   = mstart_q;
  assign running     = run_q;
endmodule : fms_sequencer
